// ### src/sac_pkg.sv
package sac_pkg;

    // ******************************************
    // clocking and timing
    // ******************************************
    localparam int          CLK_NS         = 100;
    localparam int          CLK_KHZ        = 10000;
    localparam int          SETUP_NS       = 1425;
    localparam int          CONV_NS        = 21000;
    localparam int          SCLK_MAX_KHZ   = 1100;
    localparam int          SYNC_CYC       = 2;
    // least setup time rounds up
    localparam int          SETUP_CYC_I    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  SETUP_CYC      = 8'(SETUP_CYC_I);
    // device side counts from the detected edge, which lags the pin by the synchroniser
    localparam logic [7:0]  DEV_SETUP_CYC  = 8'(SETUP_CYC_I - SYNC_CYC - 1);
    localparam logic [7:0]  HOST_SETUP_CYC = 8'(SETUP_CYC_I + SYNC_CYC);
    // longest conversion time rounds down
    localparam logic [7:0]  CONV_CYC       = 8'(CONV_NS / CLK_NS);
    localparam logic [2:0]  SCLK_HALF_CYC  =
        3'((CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ));
    localparam logic [7:0]  EOC_MIN_WAIT   = 8'h08;

    // ******************************************
    // frame layout
    // ******************************************
    localparam int          RES_W          = 10;
    localparam int          ADDR_W         = 4;
    localparam int          ANA_W          = 12;
    localparam int          NUM_CH         = 11;
    localparam logic [4:0]  FALL_SAMP      = 5'h03;
    localparam logic [4:0]  FALL_LAST      = 5'h09;
    localparam logic [3:0]  BIT_LAST       = 4'h9;
    localparam logic [2:0]  ADDR_RISES     = 3'h4;
    localparam int          FIFO_DEPTH     = 4;

    // ******************************************
    // analog scale and self-test codes
    // ******************************************
    localparam logic [11:0] REF_LO         = 12'h100;
    localparam logic [11:0] REF_HI         = 12'h4ff;
    localparam logic [11:0] TEST_MID_LVL   = 12'h300;
    localparam logic [9:0]  CODE_ZERO      = 10'h000;
    localparam logic [9:0]  CODE_FULL      = 10'h3ff;
    localparam logic [3:0]  ADDR_TEST_MID  = 4'hb;
    localparam logic [3:0]  ADDR_TEST_LO   = 4'hc;
    localparam logic [3:0]  ADDR_TEST_HI   = 4'hd;
    localparam logic [9:0]  RES_RST        = 10'h000;

endpackage : sac_pkg

// ### src/sac_link_if.sv
`timescale 1ns/1ps
interface sac_link_if;
    logic sel_n;
    logic sclk;
    logic addr;
    logic dout;
    logic dout_oe;
    logic dout_line;
    logic eoc;

    // undriven data line floats high through a pull-up
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input  sel_n,
        input  sclk,
        input  addr,
        output dout,
        output dout_oe,
        output eoc
    );

    modport host (
        output sel_n,
        output sclk,
        output addr,
        input  dout_line,
        input  eoc
    );
endinterface : sac_link_if

// ### src/sac_fifo.sv
`timescale 1ns/1ps
module sac_fifo #(
    parameter int W = 10,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    // fill side
    input  wire logic         in_valid_i,
    output      logic         in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output      logic         out_valid_o,
    input  wire logic         out_ready_i,
    output      logic [W-1:0] out_data_o
);
    localparam int PW = $clog2(D) + 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
    } sac_fifo_st_t;

    sac_fifo_st_t r;
    sac_fifo_st_t n;
    logic         full;
    logic         empty;

    assign empty       = (r.wp == r.rp);
    assign full        = (r.wp[PW-2:0] == r.rp[PW-2:0]) && (r.wp[PW-1] != r.rp[PW-1]);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = r.mem[r.rp[PW-2:0]];

    always_comb begin
        n = r;
        if (in_valid_i && !full) begin
            n.mem[r.wp[PW-2:0]] = in_data_i;
            n.wp = r.wp + 1'b1;
        end
        if (out_ready_i && !empty) begin
            n.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : sac_fifo

// ### src/sac_dev.sv
`timescale 1ns/1ps
module sac_dev (
    // clock and reset
    input  wire logic                                   core_clk_i,
    input  wire logic                                   rst_n_i,
    // link
    sac_link_if.dev                                     link,
    // analog levels, channel k at [k*12 +: 12]
    input  wire logic [sac_pkg::NUM_CH*sac_pkg::ANA_W-1:0] ana_i,
    // status
    output      logic                                   busy_o,
    output      logic [sac_pkg::RES_W-1:0]              result_o
);
    // ******************************************
    // state
    // ******************************************
    typedef enum logic [3:0] {
        DS_IDLE  = 4'b0001,
        DS_SETUP = 4'b0010,
        DS_SHIFT = 4'b0100,
        DS_CONV  = 4'b1000
    } sac_dev_state_t;

    typedef struct packed {
        sac_dev_state_t              st;
        logic [2:0]                  sel_s;
        logic [2:0]                  sclk_s;
        logic [1:0]                  addr_s;
        logic [7:0]                  cnt;
        logic [4:0]                  nfall;
        logic [2:0]                  nrise;
        logic [sac_pkg::ADDR_W-1:0]  chan;
        logic [sac_pkg::RES_W-1:0]   result;
        logic [sac_pkg::RES_W-1:0]   shreg;
        logic [sac_pkg::ANA_W-1:0]   held;
        logic                        dout;
        logic                        eoc;
        logic                        samp;
    } sac_dev_st_t;

    sac_dev_st_t r;
    sac_dev_st_t n;

    // ******************************************
    // helpers
    // ******************************************
    // one code per level step above the lower reference
    function automatic logic [sac_pkg::RES_W-1:0] sat(
        input logic [sac_pkg::ANA_W-1:0] x
    );
        logic [sac_pkg::ANA_W-1:0] d;
        d = x - sac_pkg::REF_LO;
        if (x <= sac_pkg::REF_LO) begin
            sat = sac_pkg::CODE_ZERO;
        end else if (x >= sac_pkg::REF_HI) begin
            sat = sac_pkg::CODE_FULL;
        end else begin
            sat = d[sac_pkg::RES_W-1:0];
        end
    endfunction : sat

    // unused addresses fall back to the lower reference
    function automatic logic [sac_pkg::ANA_W-1:0] pick(
        input logic [sac_pkg::ADDR_W-1:0]                c,
        input logic [sac_pkg::NUM_CH*sac_pkg::ANA_W-1:0] a
    );
        pick = sac_pkg::REF_LO;
        if (c < 4'(sac_pkg::NUM_CH)) begin
            pick = a[c*sac_pkg::ANA_W +: sac_pkg::ANA_W];
        end else if (c == sac_pkg::ADDR_TEST_MID) begin
            pick = sac_pkg::TEST_MID_LVL;
        end else if (c == sac_pkg::ADDR_TEST_LO) begin
            pick = sac_pkg::REF_LO;
        end else if (c == sac_pkg::ADDR_TEST_HI) begin
            pick = sac_pkg::REF_HI;
        end
    endfunction : pick

    logic sel_low;
    logic sel_fall;
    logic clk_rise;
    logic clk_fall;

    assign sel_low  = ~r.sel_s[1];
    assign sel_fall = ~r.sel_s[1] & r.sel_s[2];
    assign clk_rise = r.sclk_s[1] & ~r.sclk_s[2];
    assign clk_fall = ~r.sclk_s[1] & r.sclk_s[2];

    // ******************************************
    // next state
    // ******************************************
    always_comb begin
        n = r;
        // pin history: only stages two and three feed any logic
        n.sel_s  = {r.sel_s[1:0], link.sel_n};
        n.sclk_s = {r.sclk_s[1:0], link.sclk};
        n.addr_s = {r.addr_s[0], link.addr};
        unique case (r.st)
            DS_IDLE: begin
                // pins are ignored until a select fall
            end
            DS_SETUP: begin
                n.cnt = r.cnt + 8'h01;
                if (r.cnt == sac_pkg::DEV_SETUP_CYC - 8'h01) begin
                    n.st = DS_SHIFT;
                end
            end
            DS_SHIFT: begin
                if (!sel_low) begin
                    n.samp = 1'b0;
                    n.st   = DS_IDLE;
                end else begin
                    // track the channel through the window so the held level is recent
                    if (r.samp) begin
                        n.held = pick(r.chan, ana_i);
                    end
                    if (clk_rise && r.nrise < sac_pkg::ADDR_RISES) begin
                        n.chan  = {r.chan[2:0], r.addr_s[1]};
                        n.nrise = r.nrise + 3'h1;
                    end
                    if (clk_fall) begin
                        n.nfall = r.nfall + 5'h01;
                        n.shreg = {r.shreg[8:0], 1'b0};
                        n.dout  = r.shreg[8];
                        if (r.nfall == sac_pkg::FALL_SAMP) begin
                            n.samp = 1'b1;
                        end
                        if (r.nfall == sac_pkg::FALL_LAST) begin
                            n.samp = 1'b0;
                            n.held = pick(r.chan, ana_i);
                            n.eoc  = 1'b0;
                            n.cnt  = 8'h00;
                            n.st   = DS_CONV;
                        end
                    end
                end
            end
            DS_CONV: begin
                n.cnt = r.cnt + 8'h01;
                // select rising here leaves the conversion running
                // extra clocks of a long transfer keep shifting zeros out
                if (clk_fall && sel_low) begin
                    n.shreg = {r.shreg[8:0], 1'b0};
                    n.dout  = r.shreg[8];
                end
                if (r.cnt == sac_pkg::CONV_CYC - 8'h01) begin
                    n.result = sat(r.held);
                    n.eoc    = 1'b1;
                    n.shreg  = sat(r.held);
                    n.dout   = n.shreg[9];
                    n.nfall  = 5'h00;
                    n.nrise  = 3'h0;
                    n.st     = sel_low ? DS_SHIFT : DS_IDLE;
                end
            end
        endcase
        // a falling select restarts from any state, old result stays put
        if (sel_fall) begin
            n.st    = DS_SETUP;
            n.cnt   = 8'h00;
            n.nfall = 5'h00;
            n.nrise = 3'h0;
            n.samp  = 1'b0;
            n.eoc   = 1'b1;
            n.shreg = r.result;
            n.dout  = r.result[9];
        end
    end

    // history flops reset to the idle pin levels so no false edge follows reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r        <= '0;
            r.st     <= DS_IDLE;
            r.sel_s  <= 3'h7;
            r.eoc    <= 1'b1;
            r.result <= sac_pkg::RES_RST;
        end else begin
            r <= n;
        end
    end

    // ******************************************
    // outputs
    // ******************************************
    // line stays released through the setup wait, so select noise never drives it
    assign link.dout    = r.dout;
    assign link.dout_oe = sel_low && (r.st != DS_SETUP) && (r.st != DS_IDLE);
    assign link.eoc     = r.eoc;
    assign busy_o       = (r.st == DS_CONV);
    assign result_o     = r.result;
endmodule : sac_dev

// ### src/sac_host.sv
`timescale 1ns/1ps
module sac_host (
    // clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_n_i,
    // link
    sac_link_if.host                           link,
    // conversion request
    input  wire logic                          req_valid_i,
    output      logic                          req_ready_o,
    input  wire logic [sac_pkg::ADDR_W-1:0]    req_addr_i,
    // received words
    output      logic                          res_valid_o,
    input  wire logic                          res_ready_i,
    output      logic [sac_pkg::RES_W-1:0]     res_data_o
);
    // ******************************************
    // state
    // ******************************************
    typedef enum logic [4:0] {
        HS_IDLE  = 5'b00001,
        HS_SETUP = 5'b00010,
        HS_CLK   = 5'b00100,
        HS_DONE  = 5'b01000,
        HS_WAIT  = 5'b10000
    } sac_host_state_t;

    typedef struct packed {
        sac_host_state_t             st;
        logic [7:0]                  cnt;
        logic [2:0]                  div;
        logic                        phase;
        logic [3:0]                  bitn;
        logic                        sclk;
        logic                        sel_n;
        logic                        addr;
        logic [sac_pkg::ADDR_W-1:0]  ash;
        logic [sac_pkg::RES_W-1:0]   rx;
        logic [1:0]                  dout_s;
        logic [1:0]                  eoc_s;
        logic                        push;
    } sac_host_st_t;

    sac_host_st_t r;
    sac_host_st_t n;
    logic         fifo_ready;

    assign req_ready_o = (r.st == HS_IDLE) && fifo_ready && r.eoc_s[1];

    // ******************************************
    // next state
    // ******************************************
    always_comb begin
        n = r;
        n.dout_s = {r.dout_s[0], link.dout_line};
        n.eoc_s  = {r.eoc_s[0], link.eoc};
        n.push   = 1'b0;
        unique case (r.st)
            HS_IDLE: begin
                // new frames only once the last result is loaded
                if (req_valid_i && req_ready_o) begin
                    n.ash   = req_addr_i;
                    n.sel_n = 1'b0;
                    n.cnt   = 8'h00;
                    n.st    = HS_SETUP;
                end
            end
            HS_SETUP: begin
                n.cnt = r.cnt + 8'h01;
                if (r.cnt == sac_pkg::HOST_SETUP_CYC - 8'h01) begin
                    n.addr  = r.ash[3];
                    n.ash   = {r.ash[2:0], 1'b0};
                    n.div   = 3'h0;
                    n.phase = 1'b0;
                    n.bitn  = 4'h0;
                    n.st    = HS_CLK;
                end
            end
            HS_CLK: begin
                n.div = r.div + 3'h1;
                if (r.div == sac_pkg::SCLK_HALF_CYC - 3'h1) begin
                    n.div   = 3'h0;
                    n.phase = ~r.phase;
                    n.sclk  = ~r.phase;
                    if (r.phase) begin
                        // last high cycle: data has settled since the previous fall
                        n.rx   = {r.rx[8:0], r.dout_s[1]};
                        n.addr = r.ash[3];
                        n.ash  = {r.ash[2:0], 1'b0};
                        n.bitn = r.bitn + 4'h1;
                        // ten clocks only, so the long-transfer limit never applies
                        if (r.bitn == sac_pkg::BIT_LAST) begin
                            n.st = HS_DONE;
                        end
                    end
                end
            end
            HS_DONE: begin
                n.sel_n = 1'b1;
                n.addr  = 1'b0;
                n.push  = 1'b1;
                n.cnt   = 8'h00;
                n.st    = HS_WAIT;
            end
            HS_WAIT: begin
                // never aborts a running conversion
                if (r.cnt != sac_pkg::EOC_MIN_WAIT) begin
                    n.cnt = r.cnt + 8'h01;
                end else if (r.eoc_s[1]) begin
                    n.st = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r       <= '0;
            r.st    <= HS_IDLE;
            r.sel_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.sel_n = r.sel_n;
    assign link.sclk  = r.sclk;
    assign link.addr  = r.addr;

    // ******************************************
    // result buffer
    // ******************************************
    sac_fifo #(
        .W (sac_pkg::RES_W),
        .D (sac_pkg::FIFO_DEPTH)
    ) sac_fifo_i (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (r.push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (r.rx),
        .out_valid_o (res_valid_o),
        .out_ready_i (res_ready_i),
        .out_data_o  (res_data_o)
    );
endmodule : sac_host

// ### tb/sac_link_checker.sv
`timescale 1ns/1ps
module sac_link_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // link
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic addr,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic eoc
);
    // ****************
    // helper counters
    // ****************
    logic [7:0] low_r;
    logic [3:0] fall_r;
    logic       sclk_r;
    logic       sel_r;

    // fall count saturates so a long frame cannot wrap back to ten
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_r  <= 8'h00;
            fall_r <= 4'h0;
            sclk_r <= 1'b0;
            sel_r  <= 1'b1;
        end else begin
            sclk_r <= sclk;
            sel_r  <= sel_n;
            low_r  <= eoc ? 8'h00 : (low_r == 8'hff ? low_r : low_r + 8'h01);
            if (sel_r && !sel_n) begin
                fall_r <= 4'h0;
            end else if (sclk_r && !sclk && fall_r != 4'hf) begin
                fall_r <= fall_r + 4'h1;
            end
        end
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_conv_exact: assert property ($rose(eoc) |-> low_r == sac_pkg::CONV_CYC)
        else $error("eoc low span differs from conversion time");
    a_conv_bound: assert property (low_r <= sac_pkg::CONV_CYC)
        else $error("conversion runs too long");
    a_eoc_tenth: assert property ($fell(eoc) |-> fall_r == 4'ha)
        else $error("eoc fell away from tenth shift fall");
    a_eoc_soon: assert property (fall_r == 4'ha && $past(fall_r) == 4'h9 |-> ##[1:8] !eoc)
        else $error("eoc did not fall after tenth shift fall");
    a_oe_idle: assert property (sel_n [*5] |-> !dout_oe)
        else $error("data driven while deselected");
    a_setup_quiet: assert property ($fell(sel_n) |-> (!dout_oe) [*8])
        else $error("data driven during select setup");
    a_start_oe: assert property ($fell(sel_n) |-> ##[8:20] dout_oe)
        else $error("select fall did not start sequence");
    a_host_setup: assert property ($fell(sel_n) |-> (!sclk) [*8] ##1 (!sclk) [*7])
        else $error("shift clock too soon after select");
    a_high_half: assert property ($rose(sclk) |-> sclk [*5])
        else $error("shift clock high phase short");
    a_low_half: assert property ($fell(sclk) |-> (!sclk) [*5])
        else $error("shift clock low phase short");
    a_addr_hold: assert property ($rose(sclk) |-> $stable(addr))
        else $error("address moved at shift rise");

    c_frame: cover property ($fell(sel_n));
    c_tenth: cover property (fall_r == 4'ha);
    c_done: cover property ($rose(eoc));
endmodule : sac_link_checker

// ### tb/serial_adc_conversion_control_tb.sv
`timescale 1ns/1ps
module serial_adc_conversion_control_tb;
    // ****************
    // signals
    // ****************
    logic                                          core_clk_i;
    logic                                          rst_n_i;
    logic [sac_pkg::NUM_CH*sac_pkg::ANA_W-1:0]     ana;
    logic                                          req_valid;
    logic                                          req_ready;
    logic [3:0]                                    req_addr;
    logic                                          res_valid;
    logic                                          res_ready;
    logic [9:0]                                    res_data;
    logic                                          busy_a;
    logic                                          busy_b;
    logic [9:0]                                    result_a;
    logic [9:0]                                    result_b;
    logic [9:0]                                    prev;
    int                                            err_total;
    int                                            checks;
    int                                            low_b;
    int                                            span_b;

    sac_link_if link_a ();
    sac_link_if link_b ();

    sac_dev sac_dev_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_a),
        .ana_i(ana), .busy_o(busy_a), .result_o(result_a));
    sac_host sac_host_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_a),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_addr_i(req_addr),
        .res_valid_o(res_valid), .res_ready_i(res_ready), .res_data_o(res_data));
    // second end driven by the bench so aborts and early clocks can be forced
    sac_dev sac_dev_b_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link_b),
        .ana_i(ana), .busy_o(busy_b), .result_o(result_b));
    sac_link_checker sac_link_checker_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .sel_n(link_a.sel_n), .sclk(link_a.sclk), .addr(link_a.addr), .dout(link_a.dout),
        .dout_oe(link_a.dout_oe), .eoc(link_a.eoc));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(negedge core_clk_i) begin
        if (link_b.eoc === 1'b0) begin
            low_b++;
        end else begin
            if (low_b != 0) span_b = low_b;
            low_b = 0;
        end
    end

    // ****************
    // compare and close
    // ****************
    task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic cmp_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            err_total++;
            $display("mismatch %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_cnt

    task automatic report_and_stop;
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [9:0] code_of(input logic [3:0] a);
        logic [11:0] v;
        if (a == 4'hb) return 10'h200;
        if (a == 4'hd) return sac_pkg::CODE_FULL;
        if (a > 4'ha) return sac_pkg::CODE_ZERO;
        v = ana[int'(a) * sac_pkg::ANA_W +: 12];
        if (v <= sac_pkg::REF_LO) return sac_pkg::CODE_ZERO;
        if (v >= sac_pkg::REF_HI) return sac_pkg::CODE_FULL;
        return 10'(v - sac_pkg::REF_LO);
    endfunction : code_of

    // ****************
    // drivers
    // ****************
    task automatic host_req(input logic [3:0] a);
        int n;
        n = 0;
        @(negedge core_clk_i);
        req_addr = a;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(negedge core_clk_i);
            n++;
        end
        @(negedge core_clk_i);
        req_valid = 1'b0;
        if (n >= 3000) cmp_flag(req_ready, 1'b1);
    endtask : host_req

    task automatic host_pop(input logic [9:0] exp);
        int n;
        n = 0;
        @(negedge core_clk_i);
        while (res_valid !== 1'b1 && n < 3000) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n >= 3000) cmp_flag(res_valid, 1'b1);
        cmp_word(res_data, exp);
        res_ready = 1'b1;
        @(negedge core_clk_i);
        res_ready = 1'b0;
    endtask : host_pop

    // early clock pulse lands inside the setup wait and must be ignored
    task automatic b_frame(input logic [3:0] a, input int nclk, input bit early,
                           output logic [10:0] got);
        got = '0;
        link_b.sel_n = 1'b0;
        if (early) begin
            repeat (5) @(negedge core_clk_i);
            link_b.addr = 1'b1;
            link_b.sclk = 1'b1;
            repeat (3) @(negedge core_clk_i);
            link_b.sclk = 1'b0;
        end
        repeat (18) @(negedge core_clk_i);
        for (int i = 0; i < nclk; i++) begin
            link_b.addr = (i < 4) ? a[3-i] : i[0];
            repeat (5) @(negedge core_clk_i);
            link_b.sclk = 1'b1;
            repeat (5) @(negedge core_clk_i);
            got[10-i] = link_b.dout_line;
            link_b.sclk = 1'b0;
        end
        repeat (5) @(negedge core_clk_i);
    endtask : b_frame

    task automatic b_wait_done;
        int n;
        n = 0;
        span_b = 0;
        link_b.sel_n = 1'b1;
        while ((link_b.eoc !== 1'b1 || span_b == 0) && n < 500) begin
            @(negedge core_clk_i);
            n++;
        end
        cmp_cnt(span_b, int'(sac_pkg::CONV_CYC));
        cmp_flag(busy_b, 1'b0);
    endtask : b_wait_done

    // ****************
    // scenarios
    // ****************
    task automatic t_host_batch(input logic [3:0] a0, a1, a2, a3);
        logic [3:0] q[4];
        q = '{a0, a1, a2, a3};
        foreach (q[i]) host_req(q[i]);
        repeat (400) @(negedge core_clk_i);
        cmp_flag(req_ready, 1'b0);
        cmp_flag(busy_a, 1'b0);
        cmp_word(result_a, code_of(q[3]));
        foreach (q[i]) begin
            host_pop(prev);
            prev = code_of(q[i]);
        end
        cmp_flag(res_valid, 1'b0);
    endtask : t_host_batch

    task automatic t_dev_frames;
        logic [10:0] got;
        b_frame(4'hb, 11, 1'b0, got);
        cmp_flag(busy_b, 1'b1);
        cmp_word(got[10:1], sac_pkg::RES_RST);
        cmp_flag(got[0], 1'b0);
        b_wait_done();
        cmp_word(result_b, 10'h200);
        b_frame(4'h2, 10, 1'b0, got);
        cmp_word(got[10:1], 10'h200);
        link_b.sel_n = 1'b1;
        repeat (50) @(negedge core_clk_i);
        b_frame(4'h4, 10, 1'b1, got);
        cmp_word(got[10:1], 10'h200);
        repeat (40) @(negedge core_clk_i);
        cmp_word(result_b, 10'h200);
        cmp_flag(busy_b, 1'b1);
        b_wait_done();
        cmp_word(result_b, code_of(4'h4));
    endtask : t_dev_frames

    initial begin
        repeat (30000) @(posedge core_clk_i);
        err_total++;
        report_and_stop();
    end

    initial begin
        err_total = 0;
        checks = 0;
        prev = sac_pkg::RES_RST;
        rst_n_i = 1'b0;
        req_valid = 1'b0;
        req_addr = 4'h0;
        res_ready = 1'b0;
        link_b.sel_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.addr = 1'b0;
        ana = '0;
        ana[11:0] = 12'h050;
        ana[23:12] = 12'h100;
        ana[35:24] = 12'h4ff;
        ana[47:36] = 12'h7ff;
        ana[59:48] = 12'h234;
        ana[71:60] = 12'h101;
        ana[83:72] = 12'h4fe;
        repeat (20) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        t_host_batch(4'h0, 4'h1, 4'h2, 4'h3);
        t_host_batch(4'hb, 4'hc, 4'hd, 4'h4);
        t_host_batch(4'h5, 4'h6, 4'he, 4'h4);
        t_dev_frames();
        report_and_stop();
    end
endmodule : serial_adc_conversion_control_tb
